// >>> common/reading_phase_pkg.sv
// constants, types and register map of the reading phase controller
package reading_phase_pkg;
  // timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int MS_NS         = 1000000;
  localparam int MS_CYCLES     = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // timeout limits in ms
  localparam logic [13:0] TMO_MIN_MS = 14'h0028;
  localparam logic [13:0] TMO_MAX_MS = 14'h3A98;
  localparam logic [13:0] TMO_RST    = 14'h0028;
  // highest character allowed in the match code
  localparam logic [7:0]  CHAR_MAX   = 8'h7E;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_TMO    = 8'h04;
  localparam logic [7:0] OFS_MATCH  = 8'h08;
  localparam logic [7:0] OFS_WSTR   = 8'h0C;
  localparam logic [7:0] OFS_LEN    = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  // field positions of the character write and length registers
  localparam int CHAR_LSB  = 0;
  localparam int IDX_LSB   = 8;
  localparam int MLEN_LSB  = 0;
  localparam int WLEN_LSB  = 8;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  // digital inputs
  localparam int NUM_IN   = 4;
  localparam int IN_SEL_W = 2;
  // sizes of stored strings
  localparam int MAX_CODE = 64;
  localparam int WSTR_MAX = 128;

  typedef enum logic [1:0] {
    MODE_ONE    = 2'b00,
    MODE_TWO    = 2'b01,
    MODE_SERIAL = 2'b11
  } mode_e;

  typedef enum logic [1:0] {
    SH_DISABLED  = 2'b00,
    SH_TRIGGERED = 2'b01,
    SH_ENABLED   = 2'b11
  } shutter_e;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_OPEN = 2'b01,
    PH_HOLD = 2'b11
  } phase_e;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_CODE = 2'b01,
    TX_STR  = 2'b11
  } tx_e;

  // control register layout, bit 0 at the bottom
  typedef struct packed {
    logic [12:0]         spare;
    logic [IN_SEL_W-1:0] store_sel;
    logic [IN_SEL_W-1:0] stop_sel;
    logic [IN_SEL_W-1:0] start_sel;
    logic                store_pol;
    logic                stop_pol;
    logic                start_pol;
    shutter_e            shutter;
    logic                wstr_tx;
    logic                wcode_tx;
    logic                verify_en;
    logic                ext_phase;
    logic                tmo_origin;
    logic                tmo_en;
    mode_e               mode;
  } ctrl_s;

  // one decoded character from the decoder
  typedef struct packed {
    logic       valid;
    logic       last;
    logic [7:0] data;
  } dec_s;
endpackage

// >>> hdl/code_verifier.sv
// match code store, decoded code buffer and streaming comparison
module code_verifier
  import reading_phase_pkg::*;
#(
  parameter int MAXC = MAX_CODE,
  parameter int LW   = $clog2(MAXC + 1)
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    sw_we,
  input  wire logic [LW-2:0]           sw_idx,
  input  wire logic [7:0]              sw_char,
  input  wire logic                    len_we,
  input  wire logic [LW-1:0]           len_val,
  input  wire logic                    learn,
  input  wire reading_phase_pkg::dec_s dec,
  input  wire logic [LW-2:0]           rd_idx,
  output logic      [7:0]              rd_char,
  output logic                         done,
  output logic                         match,
  output logic      [LW-1:0]           code_len,
  output logic      [LW-1:0]           match_len
);
  import reading_phase_pkg::*;

  logic [7:0]    match_mem [MAXC];
  logic [7:0]    code_mem  [MAXC];
  logic [LW-1:0] pos_reg;
  logic          mism_reg;
  logic          bad_reg;
  logic          done_reg;
  logic          match_reg;
  logic [LW-1:0] code_len_reg;
  logic [LW-1:0] match_len_reg;

  // per character decisions; too long a code is a mismatch and its tail is dropped
  wire              in_range = pos_reg < LW'(MAXC);
  wire [LW-2:0]     pos_idx  = pos_reg[LW-2:0];
  wire              char_ok  = dec.data <= CHAR_MAX;
  wire              mism_now = mism_reg | ~in_range | (pos_reg >= match_len_reg)
                               | (dec.data != match_mem[pos_idx]);
  wire              bad_now  = bad_reg | ~char_ok | ~in_range;
  wire [LW-1:0]     pos_inc  = pos_reg + LW'(1);

  assign rd_char   = code_mem[rd_idx];
  assign done      = done_reg;
  assign match     = match_reg;
  assign code_len  = code_len_reg;
  assign match_len = match_len_reg;

  // storage; a learned character wins over a software write in the same cycle
  always_ff @(posedge pclk) begin
    if (dec.valid && in_range) begin
      code_mem[pos_idx] <= dec.data;
    end
    if (dec.valid && learn && in_range && char_ok) begin
      match_mem[pos_idx] <= dec.data; // R7
    end else if (sw_we && sw_char <= CHAR_MAX) begin
      match_mem[sw_idx] <= sw_char; // R6
    end
  end

  // comparison state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_reg       <= '0;
      mism_reg      <= 1'b0;
      bad_reg       <= 1'b0;
      done_reg      <= 1'b0;
      match_reg     <= 1'b0;
      code_len_reg  <= '0;
      match_len_reg <= '0;
    end else begin
      done_reg <= dec.valid & dec.last;
      if (dec.valid && !dec.last) begin
        pos_reg  <= in_range ? pos_inc : pos_reg;
        mism_reg <= mism_now;
        bad_reg  <= bad_now;
      end else if (dec.valid) begin
        match_reg    <= ~mism_now & (pos_inc == match_len_reg); // R21
        code_len_reg <= in_range ? pos_inc : pos_reg;
        pos_reg      <= '0;
        mism_reg     <= 1'b0;
        bad_reg      <= 1'b0;
        if (learn && !bad_now) begin
          match_len_reg <= pos_inc; // R7
        end
      end
      if (len_we && !(dec.valid && dec.last && learn)) begin
        match_len_reg <= (len_val > LW'(MAXC)) ? LW'(MAXC) : len_val;
      end
    end
  end
endmodule

// >>> hdl/reading_phase_controller.sv
// reading phase controller: phase sequencing, timeout, verifier, laser
// What this block does
// R1 - timeout enable only for serial, one-input
// R2 - timeout programmable 40 to 15000 ms
// R3 - origin start: count from phase start
// R4 - origin stop: count from stop, prolonging
// R5 - verify mode compares codes to match code
// R6 - match code characters 00h to 7Eh only
// R7 - store input before phase teaches code
// R8 - selectable polarity on trigger, stop, store
// R9 - wrong-code enable sends mismatching decoded code
// R10 - wrong-string enable sends up to 128 chars
// R11 - shutter disabled: laser always on; here held off while presetn is low
// R12 - shutter triggered: off after read/phase end
// R13 - shutter enabled: laser off, reading suspended
// R14 - two inputs: start asserts, stop deasserts
// R15 - extended phase: stop needs start deasserted
// R16 - start input selectable
// R17 - stop input selectable independently
// R18 - one input: phase follows sensor, results after
// R19 - serial: strings open, stop/timeout close
// R20 - ms tick timeout closes same cycle
// R21 - mismatch on length or content difference
//
// Design decisions made here: the APB slave port and the register addresses.
module reading_phase_controller
  import reading_phase_pkg::*;
#(
  parameter int MS_CNT = MS_CYCLES,
  parameter int MAXC   = MAX_CODE,
  parameter int WMAX   = WSTR_MAX
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic [NUM_IN-1:0]       din,
  input  wire logic                    ser_start,
  input  wire logic                    ser_stop,
  input  wire reading_phase_pkg::dec_s dec_in,
  output logic                         phase_active,
  output logic                         laser_on,
  output logic                         good_read,
  output logic                         mismatch_read,
  output logic                         no_read,
  output logic                         tx_valid,
  output logic      [7:0]              tx_data,
  input  wire logic                    tx_ready
);
  import reading_phase_pkg::*;

  localparam int LW  = $clog2(MAXC + 1);
  localparam int WW  = $clog2(WMAX + 1);
  localparam int MSW = $clog2(MS_CNT);

  // asserted level of an input for a polarity: 1 active closed, 0 active open
  function automatic logic asserted(input logic pin, input logic pol);
    return pol ? pin : ~pin;
  endfunction

  // keep a timeout inside the supported range
  function automatic logic [13:0] clamp_tmo(input logic [13:0] v);
    if (v < TMO_MIN_MS) return TMO_MIN_MS;
    if (v > TMO_MAX_MS) return TMO_MAX_MS;
    return v;
  endfunction

  ctrl_s                ctrl_reg;
  logic [13:0]          tmo_reg;
  logic [WW-1:0]        wlen_reg;
  logic [7:0]           wstr_mem [WMAX];
  logic [NUM_IN-1:0]    sync1_reg;
  logic [NUM_IN-1:0]    sync2_reg;
  logic [1:0]           lvl_d_reg;
  phase_e               phase_reg;
  phase_e               phase_next;
  logic                 learn_reg;
  logic                 got_code_reg;
  logic                 mism_seen_reg;
  logic                 tmo_run_reg;
  logic [MSW-1:0]       ms_cnt_reg;
  logic [13:0]          tmo_cnt_reg;
  tx_e                  tx_reg;
  logic [7:0]           tx_idx_reg;
  logic [2:0]           last_res_reg;
  logic                 pready_reg;
  logic                 pslverr_reg;
  logic [31:0]          prdata_reg;
  logic                 phase_active_reg;
  logic                 laser_reg;
  logic                 good_reg;
  logic                 mism_reg;
  logic                 noread_reg;
  logic                 tx_valid_reg;
  logic [7:0]           tx_data_reg;
  logic                 ver_done;
  logic                 ver_match;
  logic [LW-1:0]        code_len;
  logic [LW-1:0]        match_len;
  logic [7:0]           code_char;

  // apb decode; one wait-free access phase, answer prepared in setup
  wire setup    = psel & ~penable;
  wire wr_fire  = psel & penable & pwrite & pready_reg;
  wire hit_ctrl = paddr == OFS_CTRL;
  wire hit_tmo  = paddr == OFS_TMO;
  wire hit_mat  = paddr == OFS_MATCH;
  wire hit_wstr = paddr == OFS_WSTR;
  wire hit_len  = paddr == OFS_LEN;
  wire hit_stat = paddr == OFS_STATUS;
  wire mapped   = hit_ctrl | hit_tmo | hit_mat | hit_wstr | hit_len | hit_stat;
  wire [7:0] wr_idx = pwdata[IDX_LSB +: 8];
  wire [7:0] wr_chr = pwdata[CHAR_LSB +: 8];

  // selected, polarity corrected input levels from the second sync stage
  wire start_lvl = asserted(sync2_reg[ctrl_reg.start_sel], ctrl_reg.start_pol); // R8 R16
  wire stop_lvl  = asserted(sync2_reg[ctrl_reg.stop_sel], ctrl_reg.stop_pol); // R8 R17
  wire store_lvl = asserted(sync2_reg[ctrl_reg.store_sel], ctrl_reg.store_pol); // R8
  wire start_rise = start_lvl & ~lvl_d_reg[0];
  wire start_fall = ~start_lvl & lvl_d_reg[0];
  wire stop_fall  = ~stop_lvl & lvl_d_reg[1];
  wire suspend    = ctrl_reg.shutter == SH_ENABLED; // R13

  // open and close events for each variant
  wire two_close = stop_fall & (~ctrl_reg.ext_phase | ~start_lvl); // R14 R15
  wire open_evt  = (ctrl_reg.mode == MODE_SERIAL) ? ser_start : start_rise; // R14 R18 R19
  wire close_evt = (ctrl_reg.mode == MODE_SERIAL) ? ser_stop  : // R19
                   (ctrl_reg.mode == MODE_TWO)    ? two_close : start_fall; // R18

  // timeout only in serial and one-input variants
  wire tmo_ok   = ctrl_reg.tmo_en & (ctrl_reg.mode != MODE_TWO); // R1
  wire tick     = tmo_run_reg & (ms_cnt_reg == MSW'(MS_CNT - 1)); // R20
  wire [13:0] tmo_inc = tmo_cnt_reg + 14'h0001;
  wire expire   = tick & (tmo_inc >= tmo_reg); // R20

  // phase sequencing; expiry closes in the cycle the count is reached
  always_comb begin
    phase_next = phase_reg;
    case (phase_reg)
      PH_IDLE: begin
        if (open_evt && !suspend) begin
          phase_next = PH_OPEN;
        end
      end
      PH_OPEN: begin
        if (close_evt && tmo_ok && ctrl_reg.tmo_origin) begin
          phase_next = PH_HOLD; // R4
        end else if (close_evt || (expire && !ctrl_reg.tmo_origin)) begin
          phase_next = PH_IDLE; // R3 R20
        end
      end
      PH_HOLD: begin
        if (expire) begin
          phase_next = PH_IDLE; // R4
        end
      end
      default: phase_next = PH_IDLE;
    endcase
    if (suspend) begin
      phase_next = PH_IDLE; // R13
    end
  end

  wire opening  = (phase_reg == PH_IDLE) & (phase_next == PH_OPEN);
  wire closing  = (phase_reg != PH_IDLE) & (phase_next == PH_IDLE) & ~suspend;
  wire tmr_load = tmo_ok & ((opening & ~ctrl_reg.tmo_origin) | // R3
                  ((phase_reg == PH_OPEN) & (phase_next == PH_HOLD))); // R4

  // decoder characters count only inside an open phase
  dec_s dec_gated;
  assign dec_gated.valid = dec_in.valid & (phase_reg == PH_OPEN) & ~suspend;
  assign dec_gated.last  = dec_in.last;
  assign dec_gated.data  = dec_in.data;

  wire verified  = ~ctrl_reg.verify_en | learn_reg | ver_match; // R5
  wire bad_code  = ver_done & ~verified; // R9 R10
  wire code_seen = got_code_reg | ver_done;

  code_verifier #(
    .MAXC(MAXC),
    .LW  (LW)
  ) u_verifier (
    .pclk     (pclk),
    .presetn  (presetn),
    .sw_we    (wr_fire & hit_mat),
    .sw_idx   (wr_idx[LW-2:0]),
    .sw_char  (wr_chr),
    .len_we   (wr_fire & hit_len),
    .len_val  (pwdata[MLEN_LSB +: LW]),
    .learn    (learn_reg),
    .dec      (dec_gated),
    .rd_idx   (tx_idx_reg[LW-2:0]),
    .rd_char  (code_char),
    .done     (ver_done),
    .match    (ver_match),
    .code_len (code_len),
    .match_len(match_len)
  );

  // register writes and read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg    <= ctrl_s'(CTRL_RST);
      tmo_reg     <= TMO_RST;
      wlen_reg    <= '0;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      pready_reg  <= setup;
      pslverr_reg <= setup & ~mapped;
      prdata_reg  <= 32'h0000_0000;
      if (setup && hit_ctrl) prdata_reg <= ctrl_reg;
      if (setup && hit_tmo)  prdata_reg <= {18'h00000, tmo_reg};
      if (setup && hit_len)  prdata_reg <= {16'h0000, 8'(wlen_reg), 8'(match_len)};
      if (setup && hit_stat) begin
        prdata_reg <= {16'h0000, 8'(code_len), 1'b0, tx_reg != TX_IDLE,
                       last_res_reg, laser_reg, phase_reg};
      end
      if (wr_fire && hit_ctrl) ctrl_reg <= ctrl_s'({13'h0000, pwdata[18:0]});
      if (wr_fire && hit_tmo)  tmo_reg  <= clamp_tmo(pwdata[13:0]); // R2
      if (wr_fire && hit_len) begin
        wlen_reg <= (pwdata[WLEN_LSB +: 8] > 8'(WMAX)) ? WW'(WMAX) : pwdata[WLEN_LSB +: WW]; // R10
      end
    end
  end

  // wrong string memory, written a character at a time
  always_ff @(posedge pclk) begin
    if (wr_fire && hit_wstr && wr_idx < 8'(WMAX)) begin
      wstr_mem[wr_idx[WW-2:0]] <= wr_chr; // R10
    end
  end

  // two-stage synchronisers for the digital inputs, edge history after them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= '1; // idle high
      sync2_reg <= '1;
      lvl_d_reg <= 2'h0;
    end else begin
      sync1_reg <= din;
      sync2_reg <= sync1_reg;
      lvl_d_reg <= {stop_lvl, start_lvl};
    end
  end

  // phase state, learn capture and result bookkeeping
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_reg     <= PH_IDLE;
      learn_reg     <= 1'b0;
      got_code_reg  <= 1'b0;
      mism_seen_reg <= 1'b0;
      last_res_reg  <= 3'h0;
    end else begin
      phase_reg <= phase_next;
      if (opening) begin
        learn_reg     <= store_lvl; // R7
        got_code_reg  <= 1'b0;
        mism_seen_reg <= 1'b0;
      end else begin
        got_code_reg  <= code_seen;
        mism_seen_reg <= mism_seen_reg | bad_code; // R5
      end
      if (closing) begin
        last_res_reg <= {~code_seen, code_seen & (mism_seen_reg | bad_code),
                         code_seen & ~(mism_seen_reg | bad_code)}; // R18
      end
    end
  end

  // millisecond timer; stops with the phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmo_run_reg <= 1'b0;
      ms_cnt_reg  <= '0;
      tmo_cnt_reg <= 14'h0000;
    end else if (tmr_load) begin
      tmo_run_reg <= 1'b1; // R3 R4
      ms_cnt_reg  <= '0;
      tmo_cnt_reg <= 14'h0000;
    end else if (phase_next == PH_IDLE) begin
      tmo_run_reg <= 1'b0;
    end else if (tmo_run_reg) begin
      ms_cnt_reg  <= tick ? '0 : ms_cnt_reg + MSW'(1);
      tmo_cnt_reg <= tick ? tmo_inc : tmo_cnt_reg; // R20
    end
  end

  // result pulses at phase end and laser drive
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_active_reg <= 1'b0;
      laser_reg        <= 1'b0;
      good_reg         <= 1'b0;
      mism_reg         <= 1'b0;
      noread_reg       <= 1'b0;
    end else begin
      phase_active_reg <= phase_next != PH_IDLE;
      good_reg         <= closing & code_seen & ~(mism_seen_reg | bad_code); // R18 R21
      mism_reg         <= closing & code_seen & (mism_seen_reg | bad_code); // R21
      noread_reg       <= closing & ~code_seen; // R18
      case (ctrl_reg.shutter)
        SH_DISABLED:  laser_reg <= 1'b1; // R11
        SH_TRIGGERED: laser_reg <= (phase_next == PH_OPEN) & ~(code_seen & ~opening); // R12
        SH_ENABLED:   laser_reg <= 1'b0; // R13
        default:      laser_reg <= 1'b0;
      endcase
    end
  end

  // mismatch transmitter; a new mismatch while busy is not reported
  wire can_load = ~tx_valid_reg | tx_ready;
  wire go_code  = ctrl_reg.wcode_tx & (code_len != '0); // R9
  wire go_str   = ctrl_reg.wstr_tx & (wlen_reg != '0); // R10
  wire code_end = tx_idx_reg >= 8'(code_len);
  wire str_end  = tx_idx_reg >= 8'(wlen_reg);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_reg       <= TX_IDLE;
      tx_idx_reg   <= 8'h00;
      tx_valid_reg <= 1'b0;
      tx_data_reg  <= 8'h00;
    end else begin
      case (tx_reg)
        TX_IDLE: begin
          tx_idx_reg <= 8'h00;
          if (can_load) tx_valid_reg <= 1'b0;
          if (bad_code && go_code) tx_reg <= TX_CODE; // R9
          else if (bad_code && go_str) tx_reg <= TX_STR; // R10
        end
        TX_CODE: begin
          if (can_load && !code_end) begin
            tx_valid_reg <= 1'b1;
            tx_data_reg  <= code_char; // R9
            tx_idx_reg   <= tx_idx_reg + 8'h01;
          end else if (can_load) begin
            tx_valid_reg <= 1'b0;
            tx_idx_reg   <= 8'h00;
            tx_reg       <= ctrl_reg.wstr_tx && wlen_reg != '0 ? TX_STR : TX_IDLE;
          end
        end
        TX_STR: begin
          if (can_load && !str_end) begin
            tx_valid_reg <= 1'b1;
            tx_data_reg  <= wstr_mem[tx_idx_reg[WW-2:0]]; // R10
            tx_idx_reg   <= tx_idx_reg + 8'h01;
          end else if (can_load) begin
            tx_valid_reg <= 1'b0;
            tx_reg       <= TX_IDLE;
          end
        end
        default: tx_reg <= TX_IDLE;
      endcase
    end
  end

  assign prdata        = prdata_reg;
  assign pready        = pready_reg;
  assign pslverr       = pslverr_reg;
  assign phase_active  = phase_active_reg;
  assign laser_on      = laser_reg;
  assign good_read     = good_reg;
  assign mismatch_read = mism_reg;
  assign no_read       = noread_reg;
  assign tx_valid      = tx_valid_reg;
  assign tx_data       = tx_data_reg;
endmodule

// >>> tb/reading_phase_sva.sv
// port checker for the reading phase controller
module reading_phase_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        phase_active,
  input wire logic        good_read,
  input wire logic        mismatch_read,
  input wire logic        no_read,
  input wire logic        tx_valid,
  input wire logic [7:0]  tx_data,
  input wire logic        tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // any result pulse
  wire logic res = good_read | mismatch_read | no_read;

  a_apb_answer: assert property (psel && !penable |=> pready)
    else $error("no pready after setup");
  a_ready_once: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("prdata not zero outside answer");
  a_result_single: assert property ($onehot0({good_read, mismatch_read, no_read}))
    else $error("two result pulses at once");
  a_result_pulse: assert property (res |=> !res)
    else $error("result pulse too long");
  // forced close by the shutter gives no pulse; the bench never does that
  a_close_result: assert property ($fell(phase_active) |-> ##[0:2] res)
    else $error("phase closed without result");
  a_result_closed: assert property (res |-> !phase_active)
    else $error("result while phase open");
  a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("tx data dropped before accept");
endmodule

bind reading_phase_controller reading_phase_sva u_sva (.pclk, .presetn, .psel, .penable,
  .prdata, .pready, .pslverr, .phase_active, .good_read, .mismatch_read, .no_read,
  .tx_valid, .tx_data, .tx_ready);

// >>> tb/sensor_host_model.sv
// presence sensors and result sink on the far side of the controller
module sensor_host_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       present,
  input  wire logic       leaving,
  input  wire logic       slow,
  output logic      [3:0] din,
  output logic            tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  // normally closed contacts: an object breaks the current, pin goes low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      din      <= 4'hF;
      tx_ready <= 1'b0;
    end else begin
      din      <= {2'h3, ~leaving, ~present};
      tx_ready <= slow ? ~tx_ready : 1'b1; // stalls every other cycle
    end
  end
endmodule

// >>> tb/test_reading_phase_controller.sv
// self-checking bench for the reading phase controller
module test_reading_phase_controller;
  timeunit 1ns;
  timeprecision 1ps;
  import reading_phase_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e; logic r;} row_s;
  logic        pclk, presetn, psel, penable, pwrite, ser_start, ser_stop, er;
  logic        present, leaving, slow, pready, pslverr, phase_active, laser_on;
  logic        good_read, mismatch_read, no_read, tx_valid, tx_ready;
  logic [7:0]  paddr, tx_data;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  din;
  dec_s        dec_in;
  ctrl_s       c;
  int          n_errors, n_compared;
  // timeout clamping and an unmapped address
  row_s        rows [5] = '{
    '{OFS_TMO, 32'h0000_000A, 32'h0000_0028, 1'b0},
    '{OFS_TMO, 32'h0000_3A99, 32'h0000_3A98, 1'b0},
    '{OFS_TMO, 32'h0000_3A98, 32'h0000_3A98, 1'b0},
    '{OFS_TMO, 32'h0000_0028, 32'h0000_0028, 1'b0},
    '{8'h18, 32'h0000_0005, 32'h0000_0000, 1'b1}};

  always #2 pclk = ~pclk;

  // short ms so a 40 ms timeout is 400 cycles
  reading_phase_controller #(.MS_CNT(10)) dut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .din, .ser_start, .ser_stop, .dec_in,
    .phase_active, .laser_on, .good_read, .mismatch_read, .no_read, .tx_valid, .tx_data,
    .tx_ready);
  sensor_host_model model (.pclk, .presetn, .present, .leaving, .slow, .din, .tx_ready);

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] v);
    n_compared++;
    if (v !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", n, e, v);
    end
  endtask

  // one apb transfer, answer taken at the edge that sees pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk iff pready);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic ser(input logic s);
    @(posedge pclk);
    if (s) ser_start <= 1'b1;
    else ser_stop <= 1'b1;
    @(posedge pclk);
    ser_start <= 1'b0;
    ser_stop <= 1'b0;
  endtask

  task automatic dcode(input string s);
    for (int i = 0; i < s.len(); i++) begin
      @(posedge pclk);
      dec_in <= '{1'b1, i == s.len() - 1, s[i]};
    end
    @(posedge pclk);
    dec_in <= '0;
  endtask

  // waits for the end-of-phase pulse; {good, mismatch, no read} in rd
  task automatic wres;
    @(posedge pclk iff (good_read | mismatch_read | no_read));
    rd = {29'h0, good_read, mismatch_read, no_read};
  endtask

  task end_of_test;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    #20us;
    n_errors++;
    $display("watchdog expired");
    end_of_test;
  end

  initial begin
    {pclk, presetn, psel, penable, pwrite, ser_start, ser_stop} = '0;
    {present, leaving, slow, paddr, pwdata, dec_in} = '0;
    repeat (4) @(posedge pclk);
    chk("laser in reset", 0, laser_on);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("laser after reset", 1, laser_on);
    apb(0, OFS_CTRL, 0);
    chk("ctrl reset", CTRL_RST, rd);
    apb(0, OFS_TMO, 0);
    chk("tmo reset", {18'h0, TMO_RST}, rd);
    foreach (rows[i]) begin
      apb(1, rows[i].a, rows[i].d);
      apb(0, rows[i].a, 0);
      chk("rdata", rows[i].e, rd);
      chk("pslverr", rows[i].r, er);
    end
    // one input, active open: phase follows the sensor
    present <= 1'b1;
    repeat (8) @(posedge pclk);
    chk("one input phase", 1, phase_active);
    present <= 1'b0;
    wres;
    chk("one input result", 1, rd);
    // two inputs: start on din 0, stop on din 1
    c = '0;
    c.mode = MODE_TWO;
    c.stop_sel = 2'h1;
    apb(1, OFS_CTRL, c);
    present <= 1'b1;
    repeat (8) @(posedge pclk);
    present <= 1'b0;
    leaving <= 1'b1;
    repeat (8) @(posedge pclk);
    chk("two input phase", 1, phase_active);
    leaving <= 1'b0;
    wres;
    chk("two input result", 1, rd);
    // serial with timeout counted from start
    c = '0;
    c.mode = MODE_SERIAL;
    c.tmo_en = 1'b1;
    apb(1, OFS_CTRL, c);
    ser(1);
    repeat (390) @(posedge pclk);
    chk("phase before expiry", 1, phase_active);
    wres;
    chk("timeout result", 1, rd);
    // origin stop keeps the phase open past the stop string
    c.tmo_origin = 1'b1;
    apb(1, OFS_CTRL, c);
    ser(1);
    repeat (20) @(posedge pclk);
    ser(0);
    repeat (300) @(posedge pclk);
    chk("prolonged phase", 1, phase_active);
    wres;
    chk("prolonged result", 1, rd);
    // match code AB; the 80h write must be refused
    apb(1, OFS_MATCH, 32'h0000_0041);
    apb(1, OFS_MATCH, 32'h0000_0142);
    apb(1, OFS_MATCH, 32'h0000_0180);
    apb(1, OFS_LEN, 32'h0000_0002);
    c = '0;
    c.mode = MODE_SERIAL;
    c.verify_en = 1'b1;
    c.wcode_tx = 1'b1;
    c.shutter = SH_TRIGGERED;
    apb(1, OFS_CTRL, c);
    ser(1);
    repeat (2) @(posedge pclk);
    chk("laser at open", 1, laser_on);
    dcode("AB");
    repeat (4) @(posedge pclk);
    chk("laser after read", 0, laser_on);
    ser(0);
    wres;
    chk("good result", 4, rd);
    // mismatch with a stalling sink
    slow <= 1'b1;
    ser(1);
    dcode("AC");
    @(posedge pclk iff tx_valid);
    chk("wrong code char", 32'h0000_0041, tx_data);
    ser(0);
    wres;
    chk("mismatch result", 2, rd);
    // store input teaches ACE
    present <= 1'b1;
    repeat (4) @(posedge pclk);
    ser(1);
    dcode("ACE");
    ser(0);
    wres;
    chk("learn result", 4, rd);
    present <= 1'b0;
    apb(0, OFS_LEN, 0);
    chk("learned length", 3, rd);
    c.shutter = SH_ENABLED;
    apb(1, OFS_CTRL, c);
    ser(1);
    repeat (4) @(posedge pclk);
    chk("laser enabled", 0, laser_on);
    chk("suspended phase", 0, phase_active);
    end_of_test;
  end
endmodule
